/* pcq_pkg.sv */
package pcq_pkg;

    // Register indices; each register is one word, so byte address is four times the index
    localparam logic [7:0] PCQ_IDX_COMPB = 8'h14;
    localparam logic [7:0] PCQ_IDX_AQA = 8'h16;
    localparam logic [7:0] PCQ_IDX_CTL = 8'h20;
    localparam logic [7:0] PCQ_IDX_COMPA = 8'h21;
    localparam logic [7:0] PCQ_IDX_AQB = 8'h22;
    localparam logic [9:0] PCQ_ADDR_COMPB = {PCQ_IDX_COMPB, 2'b00};
    localparam logic [9:0] PCQ_ADDR_AQA = {PCQ_IDX_AQA, 2'b00};
    localparam logic [9:0] PCQ_ADDR_CTL = {PCQ_IDX_CTL, 2'b00};
    localparam logic [9:0] PCQ_ADDR_COMPA = {PCQ_IDX_COMPA, 2'b00};
    localparam logic [9:0] PCQ_ADDR_AQB = {PCQ_IDX_AQB, 2'b00};

    // Reset values
    localparam logic [15:0] PCQ_COMPB_RESET = 16'h0000;
    localparam logic [15:0] PCQ_COMPA_RESET = 16'h0000;
    localparam logic [11:0] PCQ_AQ_RESET = 12'h000;
    localparam logic PCQ_DIRECT_RESET = 1'b0;
    localparam logic [1:0] PCQ_LOAD_RESET = 2'h0;
    localparam logic PCQ_OUT_RESET = 1'b0;

    // Control register field positions
    localparam int PCQ_CTL_LOAD_LSB = 0;
    localparam int PCQ_CTL_DIRECT_BIT = 4;
    localparam int PCQ_CTL_FULL_BIT = 8;

    // Action field positions inside the action register
    localparam int PCQ_ZERO_LSB = 0;
    localparam int PCQ_PERIOD_LSB = 2;
    localparam int PCQ_COMPA_UP_LSB = 4;
    localparam int PCQ_COMPA_DOWN_LSB = 6;
    localparam int PCQ_COMPB_UP_LSB = 8;
    localparam int PCQ_COMPB_DOWN_LSB = 10;
    localparam int PCQ_AQ_WIDTH = 12;

    typedef enum logic [1:0] {
        PCQ_ACT_NONE = 2'h0,
        PCQ_ACT_CLEAR = 2'h1,
        PCQ_ACT_SET = 2'h2,
        PCQ_ACT_TOGGLE = 2'h3
    } pcq_action_t;

    typedef enum logic [1:0] {
        PCQ_LOAD_ZERO = 2'h0,
        PCQ_LOAD_PERIOD = 2'h1,
        PCQ_LOAD_EITHER = 2'h2,
        PCQ_LOAD_FREEZE = 2'h3
    } pcq_load_t;

    // Time-base inputs from the counter
    typedef struct packed {
        logic [15:0] count;
        logic count_up;
        logic at_zero;
        logic at_period;
    } pcq_timebase_t;

endpackage : pcq_pkg

/* pcq_top.sv */
// Register access over APB was decided locally.
`timescale 1ns/1ps

// What this block does
// R1 - Compare active compare-B with count continuously
// R2 - Feed compare-B match to action qualifier
// R3 - Shadowing enabled after reset
// R4 - Shadow mode: accesses hit shadow copy
// R5 - Shadow loads active on selected event
// R6 - Shadow-full flag readable by software
// R7 - Direct mode: accesses hit active value
// R8 - Shadow and active share one address
// R9 - Compare events steer outputs A and B
// R10 - Code 0 leaves output unchanged
// R11 - Code 1 clears, code 2 sets
// R12 - Code 3 toggles output
// R13 - Bits 11-10: compare-B match counting down
// R14 - Bits 9-8: compare-B match counting up
// R15 - Bits 7-6: compare-A match counting down
// R16 - Bits 5-4: compare-A match counting up
// R17 - Bits 3-2: count equals period
// R18 - Period match counts as down direction
// R19 - Bits 1-0 at zero, direction up
// R20 - Load select: zero, period, either, freeze
// R21 - Full set on write, cleared on load
// R22 - Upper four action bits read zero
module pcq_top
    import pcq_pkg::*;
#(
    parameter int ADDR_WIDTH = 12
) (
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_WIDTH-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Time-base counter
    input wire pcq_timebase_t timebase,
    // PWM outputs
    output logic pwm_output_a,
    output logic pwm_output_b
);

    // The decoder needs bits 9-0 for the register map
    if (ADDR_WIDTH < 10) begin : g_bad_addr_width
        $error("pcq_top: ADDR_WIDTH must be at least 10");
    end

    // Action stages in the qualifier, in the order they apply
    localparam int NUM_STAGES = 6;

    // Compare registers
    logic [15:0] compb_active_reg;
    logic [15:0] compb_shadow_reg;
    logic [15:0] compa_active_reg;
    logic compb_full_reg;

    // Control registers
    logic direct_reg;
    pcq_load_t load_sel_reg;

    // Action registers
    logic [PCQ_AQ_WIDTH-1:0] aqa_reg;
    logic [PCQ_AQ_WIDTH-1:0] aqb_reg;

    // Output registers
    logic out_a_reg;
    logic out_b_reg;

    // Bus answer registers
    logic [31:0] prdata_reg;
    logic pready_reg;
    logic pslverr_reg;

    // Action picked from a 2-bit field of an action register
    function automatic logic apply_action(input logic cur, input logic [1:0] code);
        case (pcq_action_t'(code))
            PCQ_ACT_NONE: begin
                apply_action = cur; // see R10
            end
            PCQ_ACT_CLEAR: begin
                apply_action = 1'b0; // see R11
            end
            PCQ_ACT_SET: begin
                apply_action = 1'b1; // see R11
            end
            PCQ_ACT_TOGGLE: begin
                apply_action = ~cur; // see R12
            end
            default: begin
                apply_action = cur;
            end
        endcase
    endfunction : apply_action

    // Field select used for both outputs
    function automatic logic [1:0] field(input logic [PCQ_AQ_WIDTH-1:0] r, input int lsb);
        field = r[lsb +: 2];
    endfunction : field

    // Field position of each qualifier stage
    function automatic int stage_lsb(input int stage);
        case (stage)
            0: begin
                stage_lsb = PCQ_ZERO_LSB; // see R19
            end
            1: begin
                stage_lsb = PCQ_PERIOD_LSB; // see R17
            end
            2: begin
                stage_lsb = PCQ_COMPA_UP_LSB; // see R16
            end
            3: begin
                stage_lsb = PCQ_COMPA_DOWN_LSB; // see R15
            end
            4: begin
                stage_lsb = PCQ_COMPB_UP_LSB; // see R14
            end
            5: begin
                stage_lsb = PCQ_COMPB_DOWN_LSB; // see R13
            end
            default: begin
                stage_lsb = PCQ_ZERO_LSB;
            end
        endcase
    endfunction : stage_lsb

    // Byte-lane merge for 16-bit registers
    function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
                                            input logic lo, input logic hi);
        logic [7:0] low_byte;
        logic [7:0] high_byte;
        low_byte = lo ? d[7:0] : old[7:0];
        high_byte = hi ? d[15:8] : old[15:8];
        merge16 = {high_byte, low_byte};
    endfunction : merge16

    // Register hit, used once per register by the decoder
    function automatic logic hit(input logic [9:0] a, input logic [9:0] reg_addr,
                                 input logic in_range);
        hit = in_range && (a == reg_addr);
    endfunction : hit

    // Time-base fields
    wire logic [15:0] tb_count = timebase.count;
    wire logic tb_up = timebase.count_up;
    wire logic tb_zero = timebase.at_zero;
    wire logic tb_period = timebase.at_period;

    // Compare events
    wire logic compb_match = (tb_count == compb_active_reg); // see R1
    wire logic compa_match = (tb_count == compa_active_reg);

    // Zero and period override the counter's direction flag
    wire logic dir_up = tb_zero ? 1'b1 : // see R19
                        tb_period ? 1'b0 : // see R18
                        tb_up;

    // Qualifying event of each stage, stage 0 in the lowest bit
    wire logic [NUM_STAGES-1:0] stage_event = {
        compb_match && !dir_up, // see R2 R13
        compb_match && dir_up, // see R2 R14
        compa_match && !dir_up, // see R15
        compa_match && dir_up, // see R16
        tb_period, // see R17
        tb_zero // see R19
    };

    // Action chains: later stages override earlier ones and compare-B comes last,
    // so its match wins when several events meet in one cycle; toggles compose.
    wire logic [NUM_STAGES:0] chain_a;
    wire logic [NUM_STAGES:0] chain_b;
    assign chain_a[0] = out_a_reg;
    assign chain_b[0] = out_b_reg;

    for (genvar s = 0; s < NUM_STAGES; s++) begin : g_stage
        wire logic [1:0] code_a = field(aqa_reg, stage_lsb(s));
        wire logic [1:0] code_b = field(aqb_reg, stage_lsb(s));
        wire logic step_a = apply_action(chain_a[s], code_a);
        wire logic step_b = apply_action(chain_b[s], code_b);
        assign chain_a[s + 1] = stage_event[s] ? step_a : chain_a[s];
        // Output B sees the same events through its own register
        assign chain_b[s + 1] = stage_event[s] ? step_b : chain_b[s]; // see R9
    end

    wire logic out_a_next = chain_a[NUM_STAGES]; // see R2
    wire logic out_b_next = chain_b[NUM_STAGES]; // see R9

    // Shadow load event; freeze selects none of the three
    wire logic load_on_zero = (load_sel_reg == PCQ_LOAD_ZERO) && tb_zero;
    wire logic load_on_period = (load_sel_reg == PCQ_LOAD_PERIOD) && tb_period;
    wire logic load_on_either = (load_sel_reg == PCQ_LOAD_EITHER) && (tb_zero || tb_period);
    wire logic load_event = load_on_zero || load_on_period || load_on_either; // see R20
    wire logic shadow_load = !direct_reg && load_event; // see R5

    // APB decode: bits above 9 must be zero to hit a register
    wire logic [9:0] word_addr = paddr[9:0];
    wire logic upper_zero = ((paddr >> 10) == '0);
    wire logic sel_compb = hit(word_addr, PCQ_ADDR_COMPB, upper_zero); // see R8
    wire logic sel_aqa = hit(word_addr, PCQ_ADDR_AQA, upper_zero);
    wire logic sel_ctl = hit(word_addr, PCQ_ADDR_CTL, upper_zero);
    wire logic sel_compa = hit(word_addr, PCQ_ADDR_COMPA, upper_zero);
    wire logic sel_aqb = hit(word_addr, PCQ_ADDR_AQB, upper_zero);
    wire logic mapped = sel_compb || sel_aqa || sel_ctl || sel_compa || sel_aqb;

    // One wait cycle: the access is taken once, pready then blocks a second take
    wire logic access = psel && penable && !pready_reg;
    wire logic wr = access && pwrite && mapped;
    wire logic wr_lo = pstrb[0];
    wire logic wr_hi = pstrb[1];
    wire logic any_lane = wr_lo || wr_hi;

    // Compare-B address reaches the shadow or the active copy
    wire logic [15:0] compb_view = direct_reg ? compb_active_reg : compb_shadow_reg; // see R4 R7

    // Merged write data
    wire logic [15:0] compb_wdata = merge16(compb_view, pwdata, wr_lo, wr_hi);
    wire logic [15:0] compa_wdata = merge16(compa_active_reg, pwdata, wr_lo, wr_hi);
    wire logic [15:0] aqa_wdata = merge16({4'h0, aqa_reg}, pwdata, wr_lo, wr_hi);
    wire logic [15:0] aqb_wdata = merge16({4'h0, aqb_reg}, pwdata, wr_lo, wr_hi);

    // Write enables
    wire logic wr_compb = wr && sel_compb && any_lane;
    wire logic wr_shadow = wr_compb && !direct_reg; // see R4
    wire logic wr_active = wr_compb && direct_reg; // see R7
    wire logic wr_compa = wr && sel_compa && any_lane;
    wire logic wr_ctl = wr && sel_ctl && wr_lo;
    wire logic wr_aqa = wr && sel_aqa;
    wire logic wr_aqb = wr && sel_aqb;

    // Control register as software sees it; the full flag is read-only
    logic [31:0] ctl_view;
    always_comb begin
        ctl_view = 32'h0;
        ctl_view[PCQ_CTL_LOAD_LSB +: 2] = load_sel_reg;
        ctl_view[PCQ_CTL_DIRECT_BIT] = direct_reg;
        ctl_view[PCQ_CTL_FULL_BIT] = compb_full_reg; // see R6
    end

    // Read mux; unmapped addresses read zero
    logic [31:0] rd_value;
    always_comb begin
        rd_value = 32'h0;
        if (sel_compb) begin
            rd_value[15:0] = compb_view; // see R4 R7 R8
        end else if (sel_aqa) begin
            rd_value[PCQ_AQ_WIDTH-1:0] = aqa_reg; // see R22
        end else if (sel_aqb) begin
            rd_value[PCQ_AQ_WIDTH-1:0] = aqb_reg;
        end else if (sel_compa) begin
            rd_value[15:0] = compa_active_reg;
        end else if (sel_ctl) begin
            rd_value = ctl_view;
        end
    end

    // Active compare-B: a direct write beats a shadow load in the same cycle
    always_ff @(posedge clk) begin
        if (reset) begin
            compb_active_reg <= PCQ_COMPB_RESET;
        end else if (wr_active) begin
            compb_active_reg <= compb_wdata; // see R7
        end else if (shadow_load) begin
            compb_active_reg <= compb_shadow_reg; // see R5
        end
    end

    // Shadow compare-B; a write in the load cycle reaches the next load
    always_ff @(posedge clk) begin
        if (reset) begin
            compb_shadow_reg <= PCQ_COMPB_RESET;
        end else if (wr_shadow) begin
            compb_shadow_reg <= compb_wdata; // see R4
        end
    end

    // Active compare-A, written directly
    always_ff @(posedge clk) begin
        if (reset) begin
            compa_active_reg <= PCQ_COMPA_RESET;
        end else if (wr_compa) begin
            compa_active_reg <= compa_wdata;
        end
    end

    // Full flag: a write in the load cycle leaves it set
    always_ff @(posedge clk) begin
        if (reset) begin
            compb_full_reg <= 1'b0;
        end else if (wr_shadow) begin
            compb_full_reg <= 1'b1; // see R21
        end else if (shadow_load) begin
            compb_full_reg <= 1'b0; // see R21
        end
    end

    // Direct-write select
    always_ff @(posedge clk) begin
        if (reset) begin
            direct_reg <= PCQ_DIRECT_RESET; // see R3
        end else if (wr_ctl) begin
            direct_reg <= pwdata[PCQ_CTL_DIRECT_BIT];
        end
    end

    // Load-event select
    always_ff @(posedge clk) begin
        if (reset) begin
            load_sel_reg <= pcq_load_t'(PCQ_LOAD_RESET);
        end else if (wr_ctl) begin
            load_sel_reg <= pcq_load_t'(pwdata[PCQ_CTL_LOAD_LSB +: 2]);
        end
    end

    // Output-A actions; the upper four bits are not stored
    always_ff @(posedge clk) begin
        if (reset) begin
            aqa_reg <= PCQ_AQ_RESET;
        end else if (wr_aqa) begin
            aqa_reg <= aqa_wdata[PCQ_AQ_WIDTH-1:0]; // see R22
        end
    end

    // Output-B actions
    always_ff @(posedge clk) begin
        if (reset) begin
            aqb_reg <= PCQ_AQ_RESET;
        end else if (wr_aqb) begin
            aqb_reg <= aqb_wdata[PCQ_AQ_WIDTH-1:0];
        end
    end

    // Output A
    always_ff @(posedge clk) begin
        if (reset) begin
            out_a_reg <= PCQ_OUT_RESET;
        end else begin
            out_a_reg <= out_a_next;
        end
    end

    // Output B
    always_ff @(posedge clk) begin
        if (reset) begin
            out_b_reg <= PCQ_OUT_RESET;
        end else begin
            out_b_reg <= out_b_next;
        end
    end

    // APB answer one cycle into the access phase
    always_ff @(posedge clk) begin
        if (reset) begin
            pready_reg <= 1'b0;
        end else begin
            pready_reg <= access;
        end
    end

    // Error with the answer for an unmapped address
    always_ff @(posedge clk) begin
        if (reset) begin
            pslverr_reg <= 1'b0;
        end else begin
            pslverr_reg <= access && !mapped;
        end
    end

    // Read data stands only in the answer cycle, zero otherwise
    always_ff @(posedge clk) begin
        if (reset) begin
            prdata_reg <= 32'h0;
        end else if (access && !pwrite) begin
            prdata_reg <= rd_value;
        end else begin
            prdata_reg <= 32'h0;
        end
    end

    assign pwm_output_a = out_a_reg;
    assign pwm_output_b = out_b_reg;
    assign prdata = prdata_reg;
    assign pready = pready_reg;
    assign pslverr = pslverr_reg;

endmodule : pcq_top

/* pcq_top_properties.sv */
`timescale 1ns/1ps
module pcq_props
    import pcq_pkg::*;
#(
    parameter int ADDR_WIDTH = 12
) (
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // APB side
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_WIDTH-1:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    sequence s_wait; psel && penable && !pready; endsequence
    sequence s_pulse; pready ##1 !pready; endsequence
    wire rd_done = pready && !pwrite;
    a_one_wait: assert property (s_wait |=> s_pulse)
        else $error("pready not one cycle after access");
    a_ready_cause: assert property ($rose(pready) |-> $past(psel && penable))
        else $error("pready without access");
    a_err_ready: assert property (pslverr |-> pready)
        else $error("pslverr outside answer");
    a_idle_rdata: assert property (!pready |-> prdata == 32'h0)
        else $error("prdata not zero when idle");
    a_unmapped_err: assert property (pready && paddr[ADDR_WIDTH-1:10] != 0 |-> pslverr)
        else $error("unmapped address not refused");
    a_mapped_ok: assert property (pready && paddr == PCQ_ADDR_COMPB |-> !pslverr)
        else $error("compare-B address refused");
    a_resv_zero: assert property (rd_done && paddr == PCQ_ADDR_AQA |-> prdata[31:12] == 0)
        else $error("reserved action bits not zero");
    a_compb_upper: assert property (rd_done && paddr == PCQ_ADDR_COMPB |-> prdata[31:16] == 0)
        else $error("compare-B upper half not zero");
endmodule : pcq_props

/* tb_top.sv */
`timescale 1ns/1ps
module tb_top;
    import pcq_pkg::*;
    localparam logic [11:0] ACTL = 12'(PCQ_ADDR_CTL);
    localparam logic [11:0] ACMPB = 12'(PCQ_ADDR_COMPB);
    localparam logic [11:0] ACMPA = 12'(PCQ_ADDR_COMPA);
    localparam logic [11:0] AAQA = 12'(PCQ_ADDR_AQA);
    localparam logic [11:0] AAQB = 12'(PCQ_ADDR_AQB);
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [3:0] pstrb = 4'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic pwm_output_a;
    logic pwm_output_b;
    logic [31:0] q;
    logic err;
    logic exp_a;
    // Idle count never equals any compare value used below
    pcq_timebase_t timebase = '{16'hffff, 1'b1, 1'b0, 1'b0};
    logic [15:0] cnt_t[6] = '{16'hffff, 16'hffff, 16'h1255, 16'h1255, 16'h0009, 16'h0009};
    logic up_t[6] = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0};
    int fails = 0;
    int checked = 0;
    int cyc = 0;
    always #2.5 clk = ~clk;
    pcq_top #(.ADDR_WIDTH(12)) dut_u (.clk(clk), .reset(reset), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .timebase(timebase),
        .pwm_output_a(pwm_output_a), .pwm_output_b(pwm_output_b));
    task automatic close_out;
        if (fails == 0 && checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : close_out
    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check
    // Leading edge keeps a release and the next setup in separate time steps
    task automatic xfer(input logic [11:0] a, input logic w, input logic [31:0] d,
        input logic [3:0] s = 4'hf);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : xfer
    task automatic ev(input logic [15:0] c, input logic up, input logic z, input logic p);
        @(posedge clk);
        timebase <= '{c, up, z, p};
        @(posedge clk);
        timebase <= '{16'hffff, 1'b1, 1'b0, 1'b0};
        @(posedge clk);
    endtask : ev
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 10000) begin
            fails++;
            close_out();
        end
    end
    initial begin
        repeat (16) @(posedge clk);
        reset <= 1'b0;
        xfer(ACTL, 1'b0, 32'h0);
        check("ctl_reset", q, 32'h0);
        xfer(ACMPB, 1'b1, 32'h5);
        xfer(ACTL, 1'b0, 32'h0);
        check("full_set", q, 32'h100);
        xfer(ACMPB, 1'b0, 32'h0);
        check("shadow_rd", q, 32'h5);
        xfer(AAQA, 1'b1, 32'h200);
        ev(16'h5, 1'b1, 1'b0, 1'b0);
        check("no_load", pwm_output_a, 1'b0);
        ev(16'hffff, 1'b1, 1'b1, 1'b0);
        xfer(ACTL, 1'b0, 32'h0);
        check("full_clr", q, 32'h0);
        ev(16'h5, 1'b1, 1'b0, 1'b0);
        check("cbu_set", pwm_output_a, 1'b1);
        for (int ld = 0; ld < 4; ld++) begin
            xfer(ACTL, 1'b1, 32'(ld));
            xfer(ACMPB, 1'b1, 32'h7);
            ev(16'hffff, 1'b1, 1'b1, 1'b0);
            xfer(ACTL, 1'b0, 32'h0);
            check("full_zero", q[8], ld % 2 == 1);
            ev(16'hffff, 1'b0, 1'b0, 1'b1);
            xfer(ACTL, 1'b0, 32'h0);
            check("full_prd", q[8], ld == 3);
        end
        xfer(ACTL, 1'b1, 32'h10);
        xfer(ACMPB, 1'b1, 32'h9);
        xfer(ACMPB, 1'b0, 32'h0);
        check("direct_rd", q, 32'h9);
        xfer(AAQA, 1'b1, 32'h100);
        ev(16'h9, 1'b1, 1'b0, 1'b0);
        check("direct_clr", pwm_output_a, 1'b0);
        exp_a = 1'b0;
        xfer(ACMPA, 1'b1, 32'h1234);
        xfer(ACMPA, 1'b1, 32'hff55, 4'h1);
        xfer(ACMPA, 1'b0, 32'h0);
        check("strobe", q, 32'h1255);
        for (int f = 0; f < 6; f++) begin
            for (int c = 0; c < 4; c++) begin
                xfer(AAQA, 1'b1, c << (2 * f));
                // Opposite direction must leave the output alone
                if (f > 1) ev(cnt_t[f ^ 1], up_t[f ^ 1], 1'b0, 1'b0);
                ev(cnt_t[f], up_t[f], f == 0, f == 1);
                exp_a = (c == 1) ? 1'b0 : (c == 2) ? 1'b1 : (c == 3) ? !exp_a : exp_a;
                xfer(AAQA, 1'b0, 32'h0);
                check("aq_rd", q, c << (2 * f));
                check("pwm_a", pwm_output_a, exp_a);
            end
        end
        xfer(AAQA, 1'b1, 32'hffff);
        xfer(AAQA, 1'b0, 32'h0);
        check("aq_resv", q, 32'h0fff);
        xfer(12'h400, 1'b1, 32'h1);
        check("wr_err", err, 1'b1);
        xfer(12'h400, 1'b0, 32'h0);
        check("rd_err", {q[30:0], err}, 32'h1);
        xfer(AAQB, 1'b1, 32'h2);
        ev(16'hffff, 1'b1, 1'b1, 1'b0);
        check("pwm_b", pwm_output_b, 1'b1);
        close_out();
    end
endmodule : tb_top
bind pcq_top pcq_props #(.ADDR_WIDTH(ADDR_WIDTH)) props_u (.clk(clk), .reset(reset),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata),
    .pready(pready), .pslverr(pslverr));
